// [cpucs_map.vh]
/*
 * Constants for the CPU state and vector block: vector addresses, flag
 * positions, reset values, stack bounds and micro-operation codes.
 * Assumes it is included by bare name from the design files.
 */
`ifndef CPUCS_MAP_VH
`define CPUCS_MAP_VH

// ----------------------------------------------------------------------
// Vector and table addresses
// ----------------------------------------------------------------------
`define CPUCS_RESET_VEC_LO 16'hFFFE
`define CPUCS_VEC_PAGE_HI 8'hFF
`define CPUCS_RESET_PC_HI 8'hFF
`define CPUCS_RESET_PC_LO 8'hFE
`define CPUCS_TABLE_BASE 16'hFFC0
`define CPUCS_TABLE_TOP_IDX 4'hF
`define CPUCS_PAGE_CALL_HI 8'hFF
`define CPUCS_BANK_REG_ADDR 8'hF3

// ----------------------------------------------------------------------
// Interrupt vector low bytes, indexed by source number, then the trap vector
// ----------------------------------------------------------------------
`define CPUCS_VEC_WATCH 8'hE8
`define CPUCS_VEC_SERIAL 8'hEA
`define CPUCS_VEC_CONV 8'hEC
`define CPUCS_VEC_CARRIER 8'hEE
`define CPUCS_VEC_EXT2 8'hF0
`define CPUCS_VEC_TIMER1 8'hF2
`define CPUCS_VEC_TIMER0 8'hF4
`define CPUCS_VEC_EXT1 8'hF6
`define CPUCS_VEC_EXT0 8'hF8
`define CPUCS_VEC_INTERVAL 8'hFA
`define CPUCS_VEC_KEYSCAN 8'hFC
`define CPUCS_VEC_TRAP 8'hE0

// ----------------------------------------------------------------------
// Flag word bit positions
// ----------------------------------------------------------------------
`define CPUCS_F_C 0
`define CPUCS_F_Z 1
`define CPUCS_F_I 2
`define CPUCS_F_H 3
`define CPUCS_F_B 4
`define CPUCS_F_G 5
`define CPUCS_F_V 6
`define CPUCS_F_N 7
`define CPUCS_FLAG_RESET 8'h00

// ----------------------------------------------------------------------
// Stack and memory sizes
// ----------------------------------------------------------------------
`define CPUCS_STACK_TOP 8'hBF
`define CPUCS_PROG_MASK 16'h1FFF

// ----------------------------------------------------------------------
// Operation codes on op_i
// ----------------------------------------------------------------------
`define CPUCS_OP_NONE 5'h00
`define CPUCS_OP_ALU 5'h01
`define CPUCS_OP_MOVE 5'h02
`define CPUCS_OP_SHIFT 5'h03
`define CPUCS_OP_BITTEST 5'h04
`define CPUCS_OP_UNMASK 5'h05
`define CPUCS_OP_MASK 5'h06
`define CPUCS_OP_PAGE_ON 5'h07
`define CPUCS_OP_PAGE_OFF 5'h08
`define CPUCS_OP_OVF_RESET 5'h09
`define CPUCS_OP_LOAD_SP 5'h0A
`define CPUCS_OP_CALL 5'h0B
`define CPUCS_OP_TABLE_CALL 5'h0C
`define CPUCS_OP_PAGE_CALL 5'h0D
`define CPUCS_OP_TRAP 5'h0E
`define CPUCS_OP_SUB_EXIT 5'h0F
`define CPUCS_OP_IRQ_EXIT 5'h10
`define CPUCS_OP_JUMP 5'h11
`define CPUCS_OP_IDX_X 5'h12
`define CPUCS_OP_IDX_Y 5'h13
`define CPUCS_OP_LOAD_A 5'h14
`define CPUCS_OP_LOAD_X 5'h15
`define CPUCS_OP_LOAD_Y 5'h16
`define CPUCS_OP_LOAD_YA 5'h17
`define CPUCS_OP_PROG_WRITE 5'h18
`define CPUCS_OP_ADVANCE 5'h19

// Index register sub-functions on idx_fn_i.
`define CPUCS_IDX_INC 2'h0
`define CPUCS_IDX_DEC 2'h1
`define CPUCS_IDX_CMP 2'h2
`define CPUCS_IDX_XFER 2'h3

`endif

// [cpucs_flags.v]
/*
 * Flag word next-value logic for the CPU state block.
 * Assumes the ALU presents its result, carry, half carry and signed
 * overflow in the same cycle as the operation code.
 */
`timescale 1ns/1ps
`include "cpucs_map.vh"

module cpucs_flags (
    input wire [4:0] op_i,
    input wire [7:0] flags_i,
    input wire [7:0] result_i,
    input wire carry_i,
    input wire half_i,
    input wire ovf_i,
    input wire [7:0] mem_byte_i,
    output reg [7:0] next_flags_o
);

    // ------------------------------------------------------------------
    // Flag update
    // ------------------------------------------------------------------
    // Half carry only ever set from the ALU, overflow from the ALU or bit test;
    // clearing them is reserved for overflow reset, except that bit test copies bit 6 to overflow.
    always @* begin
        next_flags_o = flags_i;
        case (op_i)
            `CPUCS_OP_ALU: begin
                next_flags_o[`CPUCS_F_C] = carry_i;
                next_flags_o[`CPUCS_F_Z] = (result_i == 8'h00);
                if (half_i) begin
                    next_flags_o[`CPUCS_F_H] = 1'b1;
                end
                if (ovf_i) begin
                    next_flags_o[`CPUCS_F_V] = 1'b1;
                end
                next_flags_o[`CPUCS_F_N] = result_i[7];
            end
            `CPUCS_OP_MOVE: begin
                next_flags_o[`CPUCS_F_Z] = (result_i == 8'h00);
                next_flags_o[`CPUCS_F_N] = result_i[7];
            end
            `CPUCS_OP_SHIFT: begin
                next_flags_o[`CPUCS_F_C] = carry_i;
                next_flags_o[`CPUCS_F_Z] = (result_i == 8'h00);
                next_flags_o[`CPUCS_F_N] = result_i[7];
            end
            `CPUCS_OP_BITTEST: begin
                next_flags_o[`CPUCS_F_V] = mem_byte_i[6];
                next_flags_o[`CPUCS_F_N] = mem_byte_i[7];
            end
            `CPUCS_OP_UNMASK: next_flags_o[`CPUCS_F_I] = 1'b1;
            `CPUCS_OP_MASK: next_flags_o[`CPUCS_F_I] = 1'b0;
            `CPUCS_OP_PAGE_ON: next_flags_o[`CPUCS_F_G] = 1'b1;
            `CPUCS_OP_PAGE_OFF: next_flags_o[`CPUCS_F_G] = 1'b0;
            `CPUCS_OP_OVF_RESET: begin
                next_flags_o[`CPUCS_F_H] = 1'b0;
                next_flags_o[`CPUCS_F_V] = 1'b0;
            end
            default: next_flags_o = flags_i;
        endcase
    end

endmodule // cpucs_flags

// [cpucs_core.v]
/*
 * Architectural state of the 8-bit CPU: working, index, stack and
 * program counter registers, flag word, vector fetch and stack
 * save/restore sequencing.
 * Assumes the instruction sequencer issues one operation at a time on
 * op_i while busy_o is low, and that memory answers reads next cycle.
 */
// Functional notes
// - Program counter held at FFFE during reset.
// - After reset, load start address from FFFE/FFFF and run there.
// - Working register pairs with second index register as 16 bits.
// - Indexed address is index plus address; index inc, dec, compare, move.
// - Stack pointer not reset; software loads it before first call.
// - Stack addresses confined to 00 through BF, BF customary start.
// - Calls and accepted interrupts update the stack pointer automatically.
// - Decrement after each save, increment before each restore.
// - Subroutine exit restores counter; interrupt exit adds flag word.
// - Carry loaded from arithmetic, shift and rotate.
// - Zero flag set on zero result, cleared otherwise.
// - Interrupt enable gates interrupts; cleared on entry; set/clear ops.
// - Page flag clear gives page zero, set gives bank register page.
// - Half carry set from bit 3; cleared only by overflow reset op.
// - Overflow set on signed overflow; cleared by its op or by bit test.
// - Bit test copies memory bit 6 to overflow, bit 7 to negative.
// - Negative flag follows result bit 7.
// - Software trap sets break flag.
// - Program address wraps from FFFF to 0000.
// - Program memory is read-only, 8K implemented, writes ignored.
// - Table call fetches target from FFC0 for 15, descending.
// - Two-byte page call reaches the fixed page-call area.
// - Interrupt vectors at fixed top-page offsets E8 through FC.
// - External interrupt 0 vector taken from the table at F8.
// - Unused vector locations behave as ordinary program memory.
`timescale 1ns/1ps
`include "cpucs_map.vh"

module cpucs_core (
    input wire core_clk_i,
    input wire resetn_i,
    input wire [4:0] op_i,
    input wire [15:0] operand_i,
    input wire [1:0] idx_fn_i,
    input wire [7:0] result_i,
    input wire carry_i,
    input wire half_i,
    input wire ovf_i,
    input wire irq_req_i,
    input wire [3:0] irq_src_i,
    input wire [7:0] mem_rdata_i,
    input wire [7:0] ram_bank_reg_i,
    output reg [15:0] program_counter_o,
    output reg [15:0] wide_pair_reg_o,
    output reg [7:0] index_x_o,
    output reg [7:0] stack_ptr_o,
    output reg [7:0] cpu_flag_word_o,
    output reg [15:0] eff_addr_o,
    output reg [15:0] dp_addr_o,
    output reg [15:0] mem_addr_o,
    output reg [7:0] mem_wdata_o,
    output reg mem_we_o,
    output reg mem_re_o,
    output reg idx_equal_o,
    output reg irq_taken_o,
    output reg busy_o
);

    // ------------------------------------------------------------------
    // Sequencer states, one-hot
    // ------------------------------------------------------------------
    localparam [7:0] ST_IDLE = 8'b0000_0001;
    localparam [7:0] ST_PUSH_HI = 8'b0000_0010;
    localparam [7:0] ST_PUSH_LO = 8'b0000_0100;
    localparam [7:0] ST_PUSH_FL = 8'b0000_1000;
    localparam [7:0] ST_VEC_LO = 8'b0001_0000;
    localparam [7:0] ST_VEC_HI = 8'b0010_0000;
    localparam [7:0] ST_POP = 8'b0100_0000;
    localparam [7:0] ST_POP_DONE = 8'b1000_0000;

    reg [7:0] state;
    reg [15:0] vec_addr;
    reg [15:0] call_target;
    reg push_flags;
    reg [1:0] pops_left;
    reg pop_flags;
    wire [7:0] next_flags;

    // stack area bound
    // Stack addresses stay inside the low data page below the registers.
    function [15:0] stack_addr;
        input [7:0] sp;
        begin
            stack_addr = {8'h00, (sp > `CPUCS_STACK_TOP) ? `CPUCS_STACK_TOP : sp};
        end
    endfunction

    // Interrupt vector low byte for a source number.
    function [7:0] irq_vec;
        input [3:0] src;
        begin
            case (src)
                4'h0: irq_vec = `CPUCS_VEC_WATCH;
                4'h1: irq_vec = `CPUCS_VEC_SERIAL;
                4'h2: irq_vec = `CPUCS_VEC_CONV;
                4'h3: irq_vec = `CPUCS_VEC_CARRIER;
                4'h4: irq_vec = `CPUCS_VEC_EXT2;
                4'h5: irq_vec = `CPUCS_VEC_TIMER1;
                4'h6: irq_vec = `CPUCS_VEC_TIMER0;
                4'h7: irq_vec = `CPUCS_VEC_EXT1;
                4'h8: irq_vec = `CPUCS_VEC_EXT0;
                4'h9: irq_vec = `CPUCS_VEC_INTERVAL;
                4'hA: irq_vec = `CPUCS_VEC_KEYSCAN;
                default: irq_vec = `CPUCS_VEC_WATCH;
            endcase
        end
    endfunction

    // ------------------------------------------------------------------
    // Flag logic
    // ------------------------------------------------------------------
    cpucs_flags u_flags (
        .op_i(op_i),
        .flags_i(cpu_flag_word_o),
        .result_i(result_i),
        .carry_i(carry_i),
        .half_i(half_i),
        .ovf_i(ovf_i),
        .mem_byte_i(mem_rdata_i),
        .next_flags_o(next_flags)
    );

    // ------------------------------------------------------------------
    // Main sequencer
    // ------------------------------------------------------------------
    // Stack pointer is left out of the reset branch on purpose: its value
    // after reset is whatever it held, and firmware must load it.
    always @(posedge core_clk_i) begin
        if (!resetn_i) begin
            program_counter_o <= {`CPUCS_RESET_PC_HI, `CPUCS_RESET_PC_LO};
            wide_pair_reg_o <= 16'h0000;
            index_x_o <= 8'h00;
            cpu_flag_word_o <= `CPUCS_FLAG_RESET;
            eff_addr_o <= 16'h0000;
            dp_addr_o <= 16'h0000;
            state <= ST_VEC_LO;
            vec_addr <= `CPUCS_RESET_VEC_LO;
            mem_addr_o <= `CPUCS_RESET_VEC_LO;
            mem_wdata_o <= 8'h00;
            mem_we_o <= 1'b0;
            mem_re_o <= 1'b1;
            idx_equal_o <= 1'b0;
            irq_taken_o <= 1'b0;
            busy_o <= 1'b1;
            call_target <= 16'h0000;
            push_flags <= 1'b0;
            pops_left <= 2'd0;
            pop_flags <= 1'b0;
        end else begin
            mem_we_o <= 1'b0;
            mem_re_o <= 1'b0;
            irq_taken_o <= 1'b0;
            case (state)
                ST_IDLE: begin
                    cpu_flag_word_o <= next_flags;
                    dp_addr_o <= cpu_flag_word_o[`CPUCS_F_G] ?
                        {ram_bank_reg_i, operand_i[7:0]} : {8'h00, operand_i[7:0]};
                    if (irq_req_i && cpu_flag_word_o[`CPUCS_F_I]) begin
                        irq_taken_o <= 1'b1;
                        cpu_flag_word_o[`CPUCS_F_I] <= 1'b0;
                        vec_addr <= {`CPUCS_VEC_PAGE_HI, irq_vec(irq_src_i)};
                        push_flags <= 1'b1;
                        state <= ST_PUSH_HI;
                        busy_o <= 1'b1;
                    end else begin
                        case (op_i)
                            `CPUCS_OP_LOAD_A: wide_pair_reg_o[7:0] <= result_i;
                            `CPUCS_OP_LOAD_Y: wide_pair_reg_o[15:8] <= result_i;
                            `CPUCS_OP_LOAD_YA: wide_pair_reg_o <= operand_i;
                            `CPUCS_OP_LOAD_X: index_x_o <= result_i;
                            `CPUCS_OP_IDX_X: begin
                                eff_addr_o <= operand_i + {8'h00, index_x_o};
                                case (idx_fn_i)
                                    `CPUCS_IDX_INC: index_x_o <= index_x_o + 8'h01;
                                    `CPUCS_IDX_DEC: index_x_o <= index_x_o - 8'h01;
                                    `CPUCS_IDX_CMP: idx_equal_o <= (index_x_o == operand_i[7:0]);
                                    default: index_x_o <= wide_pair_reg_o[7:0];
                                endcase
                            end
                            `CPUCS_OP_IDX_Y: begin
                                eff_addr_o <= operand_i + {8'h00, wide_pair_reg_o[15:8]};
                                case (idx_fn_i)
                                    `CPUCS_IDX_INC: wide_pair_reg_o[15:8] <= wide_pair_reg_o[15:8] + 8'h01;
                                    `CPUCS_IDX_DEC: wide_pair_reg_o[15:8] <= wide_pair_reg_o[15:8] - 8'h01;
                                    `CPUCS_IDX_CMP: idx_equal_o <= (wide_pair_reg_o[15:8] == operand_i[7:0]);
                                    default: wide_pair_reg_o[15:8] <= wide_pair_reg_o[7:0];
                                endcase
                            end
                            `CPUCS_OP_ADVANCE: program_counter_o <= program_counter_o + 16'h0001;
                            `CPUCS_OP_JUMP: program_counter_o <= operand_i;
                            `CPUCS_OP_CALL: begin
                                call_target <= operand_i;
                                push_flags <= 1'b0;
                                state <= ST_PUSH_HI;
                                busy_o <= 1'b1;
                            end
                            `CPUCS_OP_PAGE_CALL: begin
                                call_target <= {`CPUCS_PAGE_CALL_HI, operand_i[7:0]};
                                push_flags <= 1'b0;
                                state <= ST_PUSH_HI;
                                busy_o <= 1'b1;
                            end
                            `CPUCS_OP_TABLE_CALL: begin
                                vec_addr <= `CPUCS_TABLE_BASE +
                                    {11'h000, (`CPUCS_TABLE_TOP_IDX - operand_i[3:0]), 1'b0};
                                push_flags <= 1'b0;
                                state <= ST_PUSH_HI;
                                busy_o <= 1'b1;
                            end
                            `CPUCS_OP_TRAP: begin
                                cpu_flag_word_o[`CPUCS_F_B] <= 1'b1;
                                vec_addr <= {`CPUCS_VEC_PAGE_HI, `CPUCS_VEC_TRAP};
                                push_flags <= 1'b1;
                                state <= ST_PUSH_HI;
                                busy_o <= 1'b1;
                            end
                            `CPUCS_OP_SUB_EXIT: begin
                                pops_left <= 2'd2;
                                pop_flags <= 1'b0;
                                state <= ST_POP;
                                busy_o <= 1'b1;
                            end
                            `CPUCS_OP_IRQ_EXIT: begin
                                pops_left <= 2'd3;
                                pop_flags <= 1'b1;
                                state <= ST_POP;
                                busy_o <= 1'b1;
                            end
                            `CPUCS_OP_LOAD_SP: stack_ptr_o <= operand_i[7:0];
                            `CPUCS_OP_PROG_WRITE: mem_we_o <= 1'b0;
                            default: busy_o <= 1'b0;
                        endcase
                    end
                end
                ST_PUSH_HI: begin
                    mem_addr_o <= stack_addr(stack_ptr_o);
                    mem_wdata_o <= program_counter_o[15:8];
                    mem_we_o <= 1'b1;
                    stack_ptr_o <= stack_ptr_o - 8'h01;
                    state <= ST_PUSH_LO;
                end
                ST_PUSH_LO: begin
                    mem_addr_o <= stack_addr(stack_ptr_o);
                    mem_wdata_o <= program_counter_o[7:0];
                    mem_we_o <= 1'b1;
                    stack_ptr_o <= stack_ptr_o - 8'h01;
                    // The op code stands only on the edge it is taken, so a
                    // table call is told apart by its pending vector address.
                    state <= push_flags ? ST_PUSH_FL :
                        ((vec_addr != 16'h0000) ? ST_VEC_LO : ST_POP_DONE);
                    if (!push_flags && vec_addr == 16'h0000) begin
                        program_counter_o <= call_target;
                    end
                end
                ST_PUSH_FL: begin
                    mem_addr_o <= stack_addr(stack_ptr_o);
                    mem_wdata_o <= cpu_flag_word_o;
                    mem_we_o <= 1'b1;
                    stack_ptr_o <= stack_ptr_o - 8'h01;
                    state <= ST_VEC_LO;
                end
                ST_VEC_LO: begin
                    mem_addr_o <= vec_addr;
                    mem_re_o <= 1'b1;
                    state <= ST_VEC_HI;
                end
                ST_VEC_HI: begin
                    program_counter_o[7:0] <= mem_rdata_i;
                    mem_addr_o <= vec_addr + 16'h0001;
                    mem_re_o <= 1'b1;
                    state <= ST_POP_DONE;
                    pops_left <= 2'd1;
                end
                ST_POP: begin
                    stack_ptr_o <= stack_ptr_o + 8'h01;
                    mem_addr_o <= stack_addr(stack_ptr_o + 8'h01);
                    mem_re_o <= 1'b1;
                    state <= ST_POP_DONE;
                end
                ST_POP_DONE: begin
                    if (pops_left == 2'd1 && mem_re_o) begin
                        program_counter_o[15:8] <= mem_rdata_i;
                    end else if (pops_left == 2'd3 && pop_flags) begin
                        cpu_flag_word_o <= mem_rdata_i;
                    end else if (pops_left == 2'd2) begin
                        program_counter_o[7:0] <= mem_rdata_i;
                    end
                    if (pops_left > 2'd1) begin
                        pops_left <= pops_left - 2'd1;
                        state <= ST_POP;
                    end else begin
                        pops_left <= 2'd0;
                        vec_addr <= 16'h0000;
                        state <= ST_IDLE;
                        busy_o <= 1'b0;
                    end
                end
                default: state <= ST_IDLE;
            endcase
        end
    end

endmodule // cpucs_core

// [cpucs_core_checker.sv]
/* Port checker for cpucs_core. Assumes one clock and a synchronous low reset. */
`timescale 1ns/1ps
`include "cpucs_map.vh"
module cpucs_core_checker (
    input wire core_clk_i,
    input wire resetn_i,
    input wire [4:0] op_i,
    input wire [7:0] result_i,
    input wire ovf_i,
    input wire irq_req_i,
    input wire [15:0] program_counter_o,
    input wire [7:0] stack_ptr_o,
    input wire [7:0] cpu_flag_word_o,
    input wire [7:0] mem_wdata_o,
    input wire mem_we_o,
    input wire irq_taken_o,
    input wire busy_o
);
    // An op counts only when idle and unrequested, because enabled interrupts win.
    wire go = !busy_o && !irq_req_i;
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (!resetn_i);
    a_reset_pc: assert property ($rose(resetn_i) |-> program_counter_o == 16'hFFFE)
        else $error("pc not at vector");
    a_unmask_sets: assert property (go && op_i == `CPUCS_OP_UNMASK |=> cpu_flag_word_o[2])
        else $error("enable not set");
    a_move_flags: assert property (go && op_i == `CPUCS_OP_MOVE |=>
        cpu_flag_word_o[1] == ($past(result_i) == 8'h00) && cpu_flag_word_o[7] == $past(result_i[7]))
        else $error("zero or sign wrong");
    a_ovf_set: assert property (go && op_i == `CPUCS_OP_ALU && ovf_i |=> cpu_flag_word_o[6])
        else $error("overflow not set");
    a_ovf_sticky: assert property ($fell(cpu_flag_word_o[6]) |-> $past(busy_o) ||
        $past(op_i) == `CPUCS_OP_OVF_RESET || $past(op_i) == `CPUCS_OP_BITTEST) else $error("v lost");
    a_irq_masks: assert property (irq_taken_o |-> ##[0:1] !cpu_flag_word_o[2])
        else $error("enable kept");
    a_push_order: assert property (irq_taken_o |=> mem_we_o && mem_wdata_o == program_counter_o[15:8]
        ##1 mem_we_o && mem_wdata_o == program_counter_o[7:0] ##1 mem_we_o) else $error("push order");
    a_sp_down: assert property (irq_taken_o |-> ##5 stack_ptr_o == $past(stack_ptr_o, 5) - 8'h03)
        else $error("sp step");
    c_irq: cover property (irq_taken_o);
    c_ovf_clear: cover property ($fell(cpu_flag_word_o[6]));
    c_move: cover property (go && op_i == `CPUCS_OP_MOVE);
endmodule // cpucs_core_checker
bind cpucs_core cpucs_core_checker chk (.core_clk_i, .resetn_i, .op_i, .result_i, .ovf_i,
    .irq_req_i, .program_counter_o, .stack_ptr_o, .cpu_flag_word_o, .mem_wdata_o, .mem_we_o,
    .irq_taken_o, .busy_o);

// [cpucs_mem_model.sv]
/* Memory beside cpucs_core. Assumes reads are answered the next cycle. */
`timescale 1ns/1ps
module cpucs_mem_model (
    input wire core_clk_i,
    input wire [15:0] mem_addr_i,
    input wire [7:0] mem_wdata_i,
    input wire mem_we_i,
    input wire mem_re_i,
    output reg [7:0] mem_rdata_o
);
    reg [7:0] ram [0:255];
    reg [7:0] last_rdata = 8'h00;
    // Page zero keeps writes; other reads give the address low byte plus 11h.
    // Reads answer while the core's registered request stands.
    // Idle cycles invert the previous bus byte, so a stale byte shows again on every second idle cycle in a row.
    always @(posedge core_clk_i) begin
        if (mem_we_i && mem_addr_i[15:8] == 8'h00)
            ram[mem_addr_i[7:0]] <= mem_wdata_i;
        last_rdata <= mem_rdata_o;
    end
    always_comb begin
        if (mem_re_i)
            mem_rdata_o = |mem_addr_i[15:8] ? mem_addr_i[7:0] + 8'h11 : ram[mem_addr_i[7:0]];
        else
            mem_rdata_o = ~last_rdata;
    end
endmodule // cpucs_mem_model

// [cpu_core_state_and_vectors_tb_top.sv]
/* Bench for cpucs_core and its memory model. Assumes the checker is bound. */
`timescale 1ns/1ps
`include "cpucs_map.vh"
module cpu_core_state_and_vectors_tb_top;
    reg core_clk_i = 1'b0;
    reg resetn_i = 1'b0;
    reg irq_req_i = 1'b0;
    reg [4:0] op_i = 5'h00;
    reg [15:0] operand_i = 16'h0000;
    reg [7:0] result_i = 8'h00;
    reg [2:0] st = 3'h0;
    reg [15:0] saved_pc;
    wire [15:0] pc, addr, ya, ea, dp;
    wire [7:0] sp, flags, rdata, wdata;
    wire we, re, busy;
    integer failures = 0;
    integer tests_run = 0;
    integer i;
    // Rows: op, result, {ovf, half, carry}, flag position, expected flag.
    reg [19:0] rows [0:8] = '{{`CPUCS_OP_MOVE, 8'h00, 3'h0, 3'h1, 1'b1},
        {`CPUCS_OP_MOVE, 8'h80, 3'h0, 3'h7, 1'b1}, {`CPUCS_OP_ALU, 8'h01, 3'h1, 3'h0, 1'b1},
        {`CPUCS_OP_SHIFT, 8'h01, 3'h0, 3'h0, 1'b0}, {`CPUCS_OP_ALU, 8'h05, 3'h2, 3'h3, 1'b1},
        {`CPUCS_OP_ALU, 8'h7F, 3'h4, 3'h6, 1'b1}, {`CPUCS_OP_ALU, 8'h01, 3'h0, 3'h6, 1'b1},
        {`CPUCS_OP_OVF_RESET, 8'h00, 3'h0, 3'h3, 1'b0}, {`CPUCS_OP_UNMASK, 8'h00, 3'h0, 3'h2, 1'b1}};
    cpucs_core uut (.core_clk_i(core_clk_i), .resetn_i(resetn_i), .op_i(op_i),
        .operand_i(operand_i), .idx_fn_i(2'h0), .result_i(result_i), .carry_i(st[0]),
        .half_i(st[1]), .ovf_i(st[2]), .irq_req_i(irq_req_i), .irq_src_i(4'h0),
        .mem_rdata_i(rdata), .ram_bank_reg_i(8'h5A), .program_counter_o(pc), .wide_pair_reg_o(ya),
        .index_x_o(), .stack_ptr_o(sp), .cpu_flag_word_o(flags), .eff_addr_o(ea), .dp_addr_o(dp),
        .mem_addr_o(addr), .mem_wdata_o(wdata), .mem_we_o(we), .mem_re_o(re), .idx_equal_o(),
        .irq_taken_o(), .busy_o(busy));
    cpucs_mem_model mem (.core_clk_i(core_clk_i), .mem_addr_i(addr), .mem_wdata_i(wdata),
        .mem_we_i(we), .mem_re_i(re), .mem_rdata_o(rdata));
    // Free-running core clock at 250 MHz.
    initial forever #2 core_clk_i = ~core_clk_i;
    // Vector word the model holds at a top-page offset.
    function [15:0] vec(input [7:0] lo);
        vec = {lo + 8'h12, lo + 8'h11};
    endfunction
    task check(input [63:0] what, input [15:0] exp, input [15:0] got);
        tests_run = tests_run + 1;
        if (got !== exp) begin
            failures = failures + 1;
            $display("MISMATCH %0s expected %h seen %h", what, exp, got);
        end
    endtask
    task give_verdict;
        $display("Comparisons %0d, mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    // Bounded wait for the sequencer to go idle; a hang ends the run.
    task wait_idle;
        integer n;
        for (n = 0; busy !== 1'b0; n = n + 1) begin
            if (n == 50) begin
                failures = failures + 1;
                give_verdict;
            end
            @(posedge core_clk_i);
            #1;
        end
    endtask
    // One op for one cycle, then idle until the block is free again.
    task issue(input [4:0] op, input [15:0] arg);
        @(posedge core_clk_i);
        op_i <= op;
        operand_i <= arg;
        @(posedge core_clk_i);
        op_i <= `CPUCS_OP_NONE;
        #1;
        wait_idle;
    endtask
    initial begin
        repeat (7) @(posedge core_clk_i);
        #1;
        check("pc", 16'hFFFE, pc);
        @(posedge core_clk_i);
        resetn_i <= 1'b1;
        #1;
        wait_idle;
        check("pc", vec(8'hFE), pc);
        $display("Reset test done");
        for (i = 0; i < 9; i = i + 1) begin
            @(posedge core_clk_i);
            result_i <= rows[i][14:7];
            st <= rows[i][6:4];
            issue(rows[i][19:15], 16'h0000);
            check("flag", 16'(rows[i][0]), 16'(flags[rows[i][3:1]]));
        end
        $display("Flag table done");
        issue(`CPUCS_OP_LOAD_YA, 16'hA55A);
        check("pair", 16'hA55A, ya);
        issue(`CPUCS_OP_IDX_X, 16'h1234);
        issue(`CPUCS_OP_IDX_X, 16'h1234);
        check("ea", 16'h1235, ea);
        issue(`CPUCS_OP_PAGE_ON, 16'h0034);
        issue(`CPUCS_OP_PAGE_OFF, 16'h0034);
        check("dp", 16'h5A34, dp);
        $display("Register test done");
        issue(`CPUCS_OP_LOAD_SP, 16'h00BF);
        check("sp", 16'h00BF, 16'(sp));
        saved_pc = pc;
        @(posedge core_clk_i);
        irq_req_i <= 1'b1;
        @(posedge core_clk_i);
        irq_req_i <= 1'b0;
        #1;
        wait_idle;
        check("pc", vec(`CPUCS_VEC_WATCH), pc);
        check("sp", 16'h00BC, 16'(sp));
        check("ien", 16'h0000, 16'(flags[2]));
        issue(`CPUCS_OP_IRQ_EXIT, 16'h0000);
        check("pc", saved_pc, pc);
        check("sp", 16'h00BF, 16'(sp));
        $display("Interrupt test done");
        issue(`CPUCS_OP_JUMP, 16'hFFFF);
        issue(`CPUCS_OP_ADVANCE, 16'h0000);
        check("pc", 16'h0000, pc);
        issue(`CPUCS_OP_CALL, 16'h2345);
        check("pc", 16'h2345, pc);
        issue(`CPUCS_OP_SUB_EXIT, 16'h0000);
        check("pc", 16'h0000, pc);
        issue(`CPUCS_OP_TABLE_CALL, 16'h000F);
        check("pc", vec(8'hC0), pc);
        issue(`CPUCS_OP_TRAP, 16'h0000);
        check("brk", 16'h0001, 16'(flags[4]));
        $display("Call test done");
        give_verdict;
    end
endmodule // cpu_core_state_and_vectors_tb_top
